// file: verilog/spg_regs.svh
`ifndef SPG_REGS_SVH
`define SPG_REGS_SVH

// APB register window, byte addresses
`define SPG_ADDR_W        12
`define SPG_CTRL_OFS      12'h000
`define SPG_STAT_OFS      12'h004
`define SPG_CNT_OFS       12'h008
`define SPG_CFG_OFS       12'h00c
`define SPG_DLY_OFS       12'h010
`define SPG_LEN_OFS       12'h014

// Control register fields
`define SPG_CTRL_CLR_BIT  0
`define SPG_CTRL_HOLD_BIT 1
`define SPG_CTRL_HOLD_RST 1'b0

// Status register fields
`define SPG_STAT_OUT_BIT  0
`define SPG_STAT_DONE_BIT 1
`define SPG_STAT_ACT_BIT  2

// Configuration register fields
`define SPG_CFG_MODE_LSB  0
`define SPG_CFG_ENA_BIT   2
`define SPG_CFG_SCLR_BIT  3

// Default cycle counts
`define SPG_DELAY_DEF     16
`define SPG_LENGTH_DEF    4

`endif

// file: verilog/spg_pkg.sv
package spg_pkg;

   // Waveform chosen at build time
   typedef enum logic [1:0] {
      SPG_STEP_UP,
      SPG_STEP_DOWN,
      SPG_IMPULSE
   } spg_mode_t;

   // Progress of the single transition
   typedef enum logic [1:0] {
      SPG_ST_DELAY,
      SPG_ST_PULSE,
      SPG_ST_DONE
   } spg_state_t;

endpackage

// file: verilog/spg_counter.sv
`timescale 1ns/100ps
module spg_counter #(
   parameter int W = 8
) (
   // Clock and reset
   input  logic         clk,
   input  logic         sys_rst,
   // Control
   input  logic         clear,
   input  logic         inc,
   // Value
   output logic [W-1:0] count
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   // Clear outranks increment so a restart never loses a cycle
   always_comb begin
      count_next = count_reg;
      if (clear) begin
         count_next = '0;
      end else if (inc) begin
         count_next = count_reg + W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

endmodule

// file: verilog/spg_apb_regs.sv
`timescale 1ns/100ps
`include "spg_regs.svh"
module spg_apb_regs
   import spg_pkg::*;
(
   // Clock and reset
   input  logic                   clk,
   input  logic                   sys_rst,
   // APB slave
   input  logic [`SPG_ADDR_W-1:0] paddr,
   input  logic                   psel,
   input  logic                   penable,
   input  logic                   pwrite,
   input  logic [31:0]            pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Read-back words
   input  logic [31:0]            stat_word,
   input  logic [31:0]            cnt_word,
   input  logic [31:0]            cfg_word,
   input  logic [31:0]            dly_word,
   input  logic [31:0]            len_word,
   // Control to the generator
   output logic                   hold,
   output logic                   soft_clr
);

   logic        hold_reg;
   logic        hold_next;
   logic        clr_reg;
   logic        clr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        wr_ctrl;

   // Address decode, shared by read mux and error answer
   function automatic logic is_mapped(input logic [`SPG_ADDR_W-1:0] a);
      return (a == `SPG_CTRL_OFS) || (a == `SPG_STAT_OFS) || (a == `SPG_CNT_OFS) ||
             (a == `SPG_CFG_OFS) || (a == `SPG_DLY_OFS) || (a == `SPG_LEN_OFS);
   endfunction

   // Zero-wait slave; unmapped or misaligned access is refused
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);
   assign wr_ctrl = psel & penable & pwrite & (paddr == `SPG_CTRL_OFS);

   // Read data latched in the setup cycle, stable through access
   always_comb begin
      hold_next   = hold_reg;
      clr_next    = 1'b0;
      prdata_next = prdata_reg;
      if (wr_ctrl) begin
         hold_next = pwdata[`SPG_CTRL_HOLD_BIT];
         clr_next  = pwdata[`SPG_CTRL_CLR_BIT];
      end
      if (psel & ~penable & ~pwrite) begin
         prdata_next = 32'h0;
         if (!is_mapped(paddr)) begin
            prdata_next = 32'h0;
         end else if (paddr == `SPG_CTRL_OFS) begin
            prdata_next[`SPG_CTRL_HOLD_BIT] = hold_reg;
         end else if (paddr == `SPG_STAT_OFS) begin
            prdata_next = stat_word;
         end else if (paddr == `SPG_CNT_OFS) begin
            prdata_next = cnt_word;
         end else if (paddr == `SPG_CFG_OFS) begin
            prdata_next = cfg_word;
         end else if (paddr == `SPG_DLY_OFS) begin
            prdata_next = dly_word;
         end else begin
            prdata_next = len_word;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hold_reg   <= `SPG_CTRL_HOLD_RST;
         clr_reg    <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         hold_reg   <= hold_next;
         clr_reg    <= clr_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata   = prdata_reg;
   assign hold     = hold_reg;
   assign soft_clr = clr_reg;

endmodule

// file: verilog/spg_top.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "spg_regs.svh"
module spg_top
   import spg_pkg::*;
#(
   parameter spg_mode_t MODE     = SPG_IMPULSE,
   parameter int        DELAY    = `SPG_DELAY_DEF,
   parameter int        LENGTH   = `SPG_LENGTH_DEF,
   parameter bit        USE_ENA  = 1'b1,
   parameter bit        USE_SCLR = 1'b1
) (
   // Clock and reset
   input  logic                   clk,
   input  logic                   sys_rst,
   // Optional qualifiers, ignored when not built in
   input  logic                   ena,
   input  logic                   sclr,
   // APB slave
   input  logic [`SPG_ADDR_W-1:0] paddr,
   input  logic                   psel,
   input  logic                   penable,
   input  logic                   pwrite,
   input  logic [31:0]            pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Waveform
   output logic                   pulse_out
);

   // Counter wide enough for the larger of the two counts
   localparam int CW = $clog2(((DELAY > LENGTH) ? DELAY : LENGTH) + 1);
   localparam logic [CW-1:0] DELAY_LAST  = CW'(DELAY - 1);
   localparam logic [CW-1:0] LENGTH_LAST = CW'(LENGTH - 1);

   spg_state_t    st_reg;
   spg_state_t    st_next;
   logic          out_reg;
   logic          out_next;
   logic [CW-1:0] cnt;
   logic          cnt_clear;
   logic          hold;
   logic          soft_clr;
   logic          ena_eff;
   logic          clr_eff;
   logic          adv;
   logic          delay_end;
   logic          length_end;
   logic [31:0]   stat_word;
   logic [31:0]   cnt_word;
   logic [31:0]   cfg_word;

   // Level before the transition; shared by reset and clear paths
   function automatic logic init_level(input spg_mode_t m);
      return (m == SPG_STEP_DOWN);
   endfunction

   // Level taken at the end of the delay
   function automatic logic delay_level(input spg_mode_t m);
      return (m != SPG_STEP_DOWN);
   endfunction

   // Absent inputs are tied off here so the ports may float outside
   assign ena_eff = USE_ENA ? ena : 1'b1;
   assign clr_eff = (USE_SCLR & sclr) | soft_clr;
   // Software hold stalls progress like a low enable
   assign adv     = ena_eff & ~hold;

   // Terminal counts; a count of one ends in the first counted cycle
   assign delay_end  = (cnt == DELAY_LAST);
   assign length_end = (cnt == LENGTH_LAST);

   // Next state and output level
   always_comb begin
      st_next  = st_reg;
      out_next = out_reg;
      if (clr_eff) begin
         st_next  = SPG_ST_DELAY;
         out_next = init_level(MODE);
      end else if (adv) begin
         case (st_reg)
            SPG_ST_DELAY: begin
               if (delay_end) begin
                  out_next = delay_level(MODE);
                  st_next  = (MODE == SPG_IMPULSE) ? SPG_ST_PULSE : SPG_ST_DONE;
               end
            end
            SPG_ST_PULSE: begin
               if (length_end) begin
                  out_next = 1'b0;
                  st_next  = SPG_ST_DONE;
               end
            end
            SPG_ST_DONE: begin
               out_next = out_reg;
            end
            default: begin
               st_next  = SPG_ST_DELAY;
               out_next = init_level(MODE);
            end
         endcase
      end
   end

   // Output is a flip-flop, so downstream sees no glitch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg  <= SPG_ST_DELAY;
         out_reg <= init_level(MODE);
      end else begin
         st_reg  <= st_next;
         out_reg <= out_next;
      end
   end

   assign pulse_out = out_reg;

   // Count restarts at each phase change; idle after the transition
   assign cnt_clear = clr_eff | (adv & ((st_reg == SPG_ST_DELAY) ? delay_end
                                      : (st_reg == SPG_ST_PULSE) ? length_end : 1'b0));

   spg_counter #(
      .W       (CW)
   ) u_cnt (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (cnt_clear),
      .inc     (adv & (st_reg != SPG_ST_DONE)),
      .count   (cnt)
   );

   // Read-back words
   always_comb begin
      stat_word = 32'h0;
      stat_word[`SPG_STAT_OUT_BIT]  = out_reg;
      stat_word[`SPG_STAT_DONE_BIT] = (st_reg == SPG_ST_DONE);
      stat_word[`SPG_STAT_ACT_BIT]  = (st_reg == SPG_ST_PULSE);
      cnt_word = 32'h0;
      cnt_word[CW-1:0] = cnt;
      cfg_word = 32'h0;
      cfg_word[`SPG_CFG_MODE_LSB +: 2] = MODE;
      cfg_word[`SPG_CFG_ENA_BIT]       = USE_ENA;
      cfg_word[`SPG_CFG_SCLR_BIT]      = USE_SCLR;
   end

   spg_apb_regs u_regs (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .paddr     (paddr),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .stat_word (stat_word),
      .cnt_word  (cnt_word),
      .cfg_word  (cfg_word),
      .dly_word  (32'(DELAY)),
      .len_word  (32'(LENGTH)),
      .hold      (hold),
      .soft_clr  (soft_clr)
   );

   // Checks on the generator; all in the one clock domain
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Output moves only at a transition edge or a clear
   AST_ONE_EDGE: assert property (
      $changed(pulse_out) |-> $past(clr_eff) || ($past(adv) && $past(st_reg) != SPG_ST_DONE))
      else $error("Output changed outside a transition");

   // Step modes never pass through the impulse phase
   AST_MODE_PATH: assert property (
      (st_reg == SPG_ST_PULSE) |-> (MODE == SPG_IMPULSE))
      else $error("Impulse phase entered in a step mode");

   // Impulse: high exactly while in the pulse phase
   AST_IMPULSE_LEVEL: assert property (
      (MODE == SPG_IMPULSE) |-> (pulse_out == (st_reg == SPG_ST_PULSE)))
      else $error("Impulse level disagrees with phase");

   // Rising step: low while delaying, high afterwards
   AST_RISE_LEVEL: assert property (
      (MODE == SPG_STEP_UP) |-> (pulse_out == (st_reg == SPG_ST_DONE)))
      else $error("Rising step level wrong");

   // Falling step: high while delaying, low afterwards
   AST_FALL_LEVEL: assert property (
      (MODE == SPG_STEP_DOWN) |-> (pulse_out == (st_reg == SPG_ST_DELAY)))
      else $error("Falling step level wrong");

   // Impulse ends after the last counted high cycle, and stays low one cycle more unless cleared
   AST_LENGTH_END: assert property (
      (st_reg == SPG_ST_PULSE && adv && !clr_eff && cnt == LENGTH_LAST)
      |=> (st_reg == SPG_ST_DONE && !pulse_out) ##1 (clr_eff || !pulse_out))
      else $error("Impulse did not end at its length");

   // Impulse is not cut short before its length
   AST_LENGTH_MIN: assert property (
      (st_reg == SPG_ST_PULSE && !clr_eff && cnt != LENGTH_LAST) |=> (st_reg == SPG_ST_PULSE))
      else $error("Impulse ended early");

   // Transition taken exactly when the delay count completes
   AST_DELAY_END: assert property (
      (st_reg == SPG_ST_DELAY && !clr_eff)
      |=> ((st_reg != SPG_ST_DELAY) == $past(adv && cnt == DELAY_LAST)))
      else $error("Transition not at the end of the delay");

   // Without the enable option progress runs unless held
   AST_ENA_OPT: assert property (
      (!USE_ENA && !hold) |-> adv)
      else $error("Progress stalled with no enable port");

   // With the clear option the input restarts the generator
   AST_SCLR_OPT: assert property (
      (USE_SCLR && sclr) |=> (st_reg == SPG_ST_DELAY && cnt == '0))
      else $error("Clear input ignored");

   // Stalled cycles freeze count, phase and level
   AST_STALL_HOLD: assert property (
      (!adv && !clr_eff) |=> ($stable(cnt) && $stable(st_reg) && $stable(pulse_out)))
      else $error("Progress while stalled");

   // Clear returns to the starting point in one edge
   AST_CLEAR_START: assert property (
      clr_eff |=> (st_reg == SPG_ST_DELAY && cnt == '0 && pulse_out == init_level(MODE)))
      else $error("Clear did not restart the generator");

   // Enable pin low freezes count, phase and level
   AST_ENA_LOW: assert property (
      (USE_ENA && !ena && !clr_eff) |=> ($stable(cnt) && $stable(st_reg) && $stable(pulse_out)))
      else $error("Progress while enable low");

   // Clear pin restores the starting level
   AST_SCLR_LEVEL: assert property (
      (USE_SCLR && sclr) |=> (pulse_out == init_level(MODE)))
      else $error("Clear pin left the wrong level");

   // Before the transition the output sits at its starting level
   AST_START_LEVEL: assert property (
      (st_reg == SPG_ST_DELAY) |-> (pulse_out == init_level(MODE)))
      else $error("Starting level wrong");

   // Once finished, phase and level stay put until a clear
   AST_FINAL_STAYS: assert property (
      (st_reg == SPG_ST_DONE && !clr_eff) |=> (st_reg == SPG_ST_DONE && $stable(pulse_out)))
      else $error("Output moved after its transition");

   // No early transition while the delay count runs
   AST_DELAY_MIN: assert property (
      (st_reg == SPG_ST_DELAY && !clr_eff && cnt != DELAY_LAST) |=> (st_reg == SPG_ST_DELAY))
      else $error("Transition before the delay ended");

   // Delay count never runs past its last value
   AST_DELAY_RANGE: assert property (
      (st_reg == SPG_ST_DELAY) |-> (cnt <= DELAY_LAST))
      else $error("Delay count overran");

   // Length count never runs past its last value
   AST_LENGTH_RANGE: assert property (
      (st_reg == SPG_ST_PULSE) |-> (cnt <= LENGTH_LAST))
      else $error("Length count overran");

   // Counter idles once finished, so only one transition is possible
   AST_DONE_IDLE: assert property (
      (st_reg == SPG_ST_DONE && !clr_eff) |=> (cnt == '0))
      else $error("Counter ran after the transition");

   // Soft clear is a single-cycle strobe, never a stuck restart
   AST_SOFT_CLR_PULSE: assert property (
      soft_clr |=> !soft_clr)
      else $error("Soft clear stuck high");

   // Impulse falls only at its end or by a clear
   AST_IMPULSE_FALL: assert property (
      (MODE == SPG_IMPULSE && $fell(pulse_out)) |-> (st_reg == SPG_ST_DONE || $past(clr_eff)))
      else $error("Impulse fell at the wrong time");

   // Main scenarios
   CVR_TRANSITION: cover property (st_reg == SPG_ST_DELAY ##1 st_reg != SPG_ST_DELAY);
   CVR_IMPULSE_DONE: cover property (st_reg == SPG_ST_PULSE ##1 st_reg == SPG_ST_DONE);
   CVR_STALL: cover property ((st_reg != SPG_ST_DONE && !adv) [*3]);
   CVR_CLEAR_AFTER: cover property (st_reg == SPG_ST_DONE ##1 clr_eff);
   CVR_HOLD: cover property (hold && st_reg == SPG_ST_DELAY);

endmodule

// file: verif/spg_sink.sv
`timescale 1ns/100ps
module spg_sink (
   // Clock and reset
   input  logic       clk,
   input  logic       sys_rst,
   // Consumed waveform
   input  logic       level,
   output logic [7:0] toggles
);
   logic last_reg;

   // Downstream logic counts every change it sees; it never drives back
   always_ff @(posedge clk) begin
      last_reg <= level;
      if (sys_rst) begin
         toggles <= 8'h00;
      end else if (level !== last_reg) begin
         toggles <= toggles + 8'h01;
      end
   end
endmodule

// file: verif/spg_tb_top.sv
`timescale 1ns/100ps
module spg_tb_top;
   import spg_pkg::*;
   localparam int D = 3;
   localparam int L = 2;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        ena = 1'b1;
   logic        sclr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata [4];
   logic [3:0]  pready;
   logic [3:0]  pslverr;
   logic [3:0]  pulse_out;
   logic [7:0]  toggles;
   logic [31:0] rnd = 32'h142210e9;
   logic [3:0]  exp_q [$];
   logic [34:0] apb_q [$];
   int          err_count = 0;
   int          checks_done = 0;
   int          n = 0;
   int          nf = 0;
   int          cyc = 0;
   logic        hold_m = 1'b0;
   logic        clr_pend = 1'b0;

   always #2.5 clk = ~clk;

   // One generator per waveform type, all fed the same stimulus; the
   // fourth is an impulse built without the enable and clear pins
   for (genvar m = 0; m < 4; m++) begin : g_mode
      spg_top #(.MODE(spg_mode_t'((m < 3) ? m : 2)), .DELAY(D), .LENGTH(L),
                .USE_ENA(m < 3), .USE_SCLR(m < 3)) u_spg_top (
         .clk(clk), .sys_rst(sys_rst), .ena(ena), .sclr(sclr), .paddr(paddr),
         .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
         .prdata(prdata[m]), .pready(pready[m]), .pslverr(pslverr[m]),
         .pulse_out(pulse_out[m]));
   end

   spg_sink u_spg_sink (.clk(clk), .sys_rst(sys_rst), .level(pulse_out[2]), .toggles(toggles));

   function automatic logic lvl(input int m, input int k);
      if (m == 0) return k >= D;
      if (m == 1) return k < D;
      return (k >= D) && (k < D + L);
   endfunction

   // Config word per instance: mode in [1:0], enable pin bit 2, clear pin bit 3
   function automatic logic [31:0] cfg_exp(input int m);
      if (m < 3) return 32'hc | 32'(m);
      return 32'h2;
   endfunction

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
      cmp_word({28'h0, got}, {28'h0, exp}, "pulse_out");
   endtask

   // Reference count of enabled edges; clear wins over advance and hold
   always @(posedge clk) begin
      if (sys_rst) begin
         n = 0;
         nf = 0;
         hold_m = 1'b0;
         clr_pend = 1'b0;
      end else begin
         if (sclr || clr_pend) n = 0;
         else if (ena && !hold_m && n < 1000) n++;
         // Pinless instance ignores enable and clear pins
         if (clr_pend) nf = 0;
         else if (!hold_m && nf < 1000) nf++;
         clr_pend = 1'b0;
         if (psel && penable && pwrite && paddr == 12'h000) begin
            hold_m = pwdata[1];
            clr_pend = pwdata[0];
         end
      end
      exp_q.push_back({lvl(2, nf), lvl(2, n), lvl(1, n), lvl(0, n)});
   end

   // Output watcher: oldest note against the settled level
   always @(negedge clk) begin
      if (exp_q.size() > 0) cmp_out(pulse_out, exp_q.pop_front());
   end

   // Bus watcher at the completing access edge
   always @(posedge clk) begin
      if (psel && penable && pready[0] && apb_q.size() > 0) begin
         logic [34:0] e;
         e = apb_q.pop_front();
         for (int m = 0; m < 4; m++) begin
            cmp_word({31'h0, pslverr[m]}, {31'h0, e[33]}, "pslverr");
            if (e[34]) cmp_word(prdata[m], e[32] ? cfg_exp(m) : e[31:0], "prdata");
         end
      end
   end

   // Hang guard, well above the planned run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic run(input int cycles, input bit noisy);
      repeat (cycles) begin
         @(posedge clk);
         rnd = xorshift(rnd);
         ena <= noisy ? (rnd[0] | rnd[1]) : 1'b1;
         sclr <= noisy ? (rnd[6:2] == 5'h00) : 1'b0;
      end
   endtask

   task automatic do_reset();
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
   endtask

   // Setup cycle, then access held until pready is seen high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] exp, input logic addm);
      apb_q.push_back({!w, (a > 12'h014) || (a[1:0] != 2'b00), addm, exp});
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready[0] !== 1'b1);
      // Idle edge so the next setup never rewrites psel in this step
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   initial begin
      do_reset();
      run(20, 1'b0);
      cmp_word({24'h0, toggles}, 32'h2, "impulse edges");
      $display("test free_run done");
      run(300, 1'b1);
      $display("test random_ena_sclr done");
      apb(12'h00c, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(12'h010, 1'b0, 32'h0, D, 1'b0);
      apb(12'h014, 1'b0, 32'h0, L, 1'b0);
      apb(12'h020, 1'b1, 32'h3, 32'h0, 1'b0);
      apb(12'h006, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(12'h000, 1'b1, 32'h2, 32'h0, 1'b0);
      apb(12'h000, 1'b0, 32'h0, 32'h2, 1'b0);
      run(10, 1'b0);
      apb(12'h000, 1'b1, 32'h0, 32'h0, 1'b0);
      run(8, 1'b0);
      apb(12'h000, 1'b1, 32'h1, 32'h0, 1'b0);
      run(10, 1'b1);
      $display("test registers done");
      run(2, 1'b0);
      do_reset();
      run(15, 1'b1);
      $display("test second_reset done");
      summarize();
   end
endmodule
